// ==== design/mpc_pkg.sv ====
// package for the monitor pin control block: register offsets, fields, reset values, timing
// assumes a 40 MHz clock and a 32-bit APB register bus
package mpc_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned RST_PULSE_MS    = 45;
    // least time in whole cycles, no round-up added
    localparam int unsigned RST_PULSE_CYC   = (RST_PULSE_MS * (CLK_HZ / 1000) + 0) ;
    localparam int unsigned RST_CNT_W       = 21;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] CFG_OFS          = 8'h40;
    localparam logic [7:0] VID_TOP_OFS      = 8'h44;
    localparam logic [7:0] VID_LOW_OFS      = 8'h48;
    localparam logic [7:0] IRQ_STAT_OFS     = 8'h4C;
    localparam logic [7:0] IRQ_MASK_OFS     = 8'h50;
    localparam logic [7:0] VID_MODE_OFS     = 8'h54;
    localparam logic [7:0] PIN_STAT_OFS     = 8'h58;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int unsigned CFG_RST_BIT     = 4;
    localparam int unsigned ST_EXT_RST_BIT  = 5;
    localparam int unsigned ST_PULSE_BIT    = 6;
    localparam logic [7:0] CFG_RST_VAL      = 8'h00;
    localparam logic [7:0] DAC_RST_VAL      = 8'h00;
    localparam logic [6:0] MASK_RST_VAL     = 7'h00;
    localparam logic [4:0] MODE_RST_VAL     = 5'h00;

    // pin status bundle sampled each cycle
    typedef struct packed {
        logic       test_en;
        logic       rst_in;
        logic [4:0] vid;
    } mpc_pins_s;

    // reset pulse generator states
    typedef enum logic [1:0] {
        MPC_RP_IDLE  = 2'b01,
        MPC_RP_PULSE = 2'b10
    } mpc_rp_e;
endpackage : mpc_pkg

// ==== design/mpc_top.sv ====
// monitor pin control: test mode pin, open-drain reset pin, voltage id capture, apb registers
// assumes pins are synchronous to clk and an apb master on the same clock
//
// What this block does
// - a high board test enable input puts the block in connectivity test mode, low is normal.
// - out of test mode the shared pin carries the analog level output code instead.
// - the reset pin is driven open-drain active low, each pulse lasting at least 45 ms.
// - an external low on the reset pin is taken as a reset input to the block.
// - the top voltage id input is sampled into bit 0 of the register that also holds the analog level output code.
// - the four low voltage id inputs are sampled together into bits 3:0 of a register of their own.
// - each voltage id input can be switched to act as an external interrupt input.
// - an external low on the reset pin returns every register to its default value; interrupt status keeps only new events and its external reset flag.
// - in test mode the address select pin becomes the test tree output.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module mpc_top
    import mpc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        board_test_enable,
    input  wire logic        reset_pin_in,
    output logic             reset_pin_out,
    output logic             reset_pin_oe,
    input  wire logic [4:0]  voltage_id_in,
    output logic             test_mode,
    output logic      [7:0]  analog_level_output,
    output logic             address_select_test_output,
    output logic             address_select_test_oe,
    output logic             irq
);
    // ************************************************************
    // reset release and pin sampling
    // ************************************************************
    logic [1:0] rst_sync_r;
    logic       srst_n;
    mpc_pins_s  pins_r;
    mpc_pins_s  pins_nxt;

    // two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n) rst_sync_r <= 2'b00;
        else        rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign srst_n = rst_sync_r[1];

    // pins are synchronous, one register stage
    always_comb
    begin
        pins_nxt.test_en = board_test_enable;
        pins_nxt.rst_in  = reset_pin_in;
        pins_nxt.vid     = voltage_id_in;
    end

    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n) pins_r <= '{test_en: 1'b0, rst_in: 1'b1, vid: 5'h1F};
        else         pins_r <= pins_nxt;
    end

    // external low on the pin, ignored while we drive it and one cycle after,
    // since the sampled pin still shows our own pulse for that cycle
    logic ext_rst;
    logic oe_prev_r;
    assign ext_rst = !pins_r.rst_in && !reset_pin_oe && !oe_prev_r;

    // ************************************************************
    // registers and reset pulse generator
    // ************************************************************
    logic [7:0]           cfg_r,  cfg_nxt;
    logic [7:0]           dac_r,  dac_nxt;
    logic [4:0]           mode_r, mode_nxt;
    logic [6:0]           stat_r, stat_nxt;
    logic [6:0]           mask_r, mask_nxt;
    logic [4:0]           vid_prev_r;
    logic                 ext_prev_r;
    mpc_rp_e              rp_r,   rp_nxt;
    logic [RST_CNT_W-1:0] cnt_r,  cnt_nxt;
    logic [31:0]          rdata_nxt;
    logic                 wr_en, rd_en, hit;
    logic [6:0]           ev;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // events: falling edge on an id pin set to interrupt role, external reset, pulse done
    always_comb
    begin
        ev        = 7'h00;
        ev[4:0]   = mode_r & vid_prev_r & ~pins_r.vid;
        ev[ST_EXT_RST_BIT] = ext_rst && !ext_prev_r;
        ev[ST_PULSE_BIT]   = (rp_r == MPC_RP_PULSE) && (cnt_r == '0);
    end

    // register writes, status set wins over write-one-to-clear
    always_comb
    begin
        cfg_nxt  = cfg_r;
        dac_nxt  = dac_r;
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        if (wr_en)
        begin
            unique case (paddr)
                CFG_OFS:      cfg_nxt  = pwdata[7:0];
                VID_TOP_OFS:  dac_nxt  = pwdata[15:8];
                IRQ_MASK_OFS: mask_nxt = pwdata[6:0];
                IRQ_STAT_OFS: stat_nxt = stat_r & ~pwdata[6:0];
                VID_MODE_OFS: mode_nxt = pwdata[4:0];
                default:      cfg_nxt  = cfg_r;
            endcase
        end
        stat_nxt = stat_nxt | ev;
        // request bit self-clears once the pulse starts
        if (rp_r == MPC_RP_IDLE && cfg_r[CFG_RST_BIT])
            cfg_nxt[CFG_RST_BIT] = 1'b0;
    end

    // pulse generator counts cycles before releasing the pin
    always_comb
    begin
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        unique case (rp_r)
            MPC_RP_IDLE:
            begin
                if (cfg_r[CFG_RST_BIT])
                begin
                    rp_nxt  = MPC_RP_PULSE;
                    cnt_nxt = RST_CNT_W'(RST_PULSE_CYC - 1);
                end
            end
            MPC_RP_PULSE:
            begin
                if (cnt_r == '0) rp_nxt  = MPC_RP_IDLE;
                else             cnt_nxt = cnt_r - 1'b1;
            end
            default:
            begin
                rp_nxt  = MPC_RP_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    // read mux, unmapped reads return zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        hit       = 1'b1;
        unique case (paddr)
            CFG_OFS:      rdata_nxt = {24'h000000, cfg_r};
            VID_TOP_OFS:  rdata_nxt = {16'h0000, dac_r, 7'h00, pins_r.vid[4]};
            VID_LOW_OFS:  rdata_nxt = {28'h0000000, pins_r.vid[3:0]};
            IRQ_STAT_OFS: rdata_nxt = {25'h0000000, stat_r};
            IRQ_MASK_OFS: rdata_nxt = {25'h0000000, mask_r};
            VID_MODE_OFS: rdata_nxt = {27'h0000000, mode_r};
            PIN_STAT_OFS: rdata_nxt = {29'h0000000, reset_pin_oe, pins_r.rst_in,
                                       pins_r.test_en};
            default:      hit       = 1'b0;
        endcase
    end

    // external reset pin low returns registers to defaults
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            cfg_r      <= CFG_RST_VAL;
            dac_r      <= DAC_RST_VAL;
            mode_r     <= MODE_RST_VAL;
            mask_r     <= MASK_RST_VAL;
            stat_r     <= 7'h00;
            vid_prev_r <= 5'h1F;
            ext_prev_r <= 1'b0;
            oe_prev_r  <= 1'b0;
            rp_r       <= MPC_RP_IDLE;
            cnt_r      <= '0;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end
        else
        begin
            if (ext_rst)
            begin
                cfg_r  <= CFG_RST_VAL;
                dac_r  <= DAC_RST_VAL;
                mode_r <= MODE_RST_VAL;
                mask_r <= MASK_RST_VAL;
                // the external reset flag survives while the pin stays low
                stat_r <= 7'h00 | ev;
                stat_r[ST_EXT_RST_BIT] <= stat_r[ST_EXT_RST_BIT] | ev[ST_EXT_RST_BIT];
            end
            else
            begin
                cfg_r  <= cfg_nxt;
                dac_r  <= dac_nxt;
                mode_r <= mode_nxt;
                mask_r <= mask_nxt;
                stat_r <= stat_nxt;
            end
            vid_prev_r <= pins_r.vid;
            ext_prev_r <= ext_rst;
            oe_prev_r  <= reset_pin_oe;
            rp_r       <= rp_nxt;
            cnt_r      <= cnt_nxt;
            if (rd_en) prdata <= rdata_nxt;
            pready     <= psel && !penable;
            pslverr    <= psel && !penable && !hit;
        end
    end

    // ************************************************************
    // pin outputs, all registered
    // ************************************************************
    always_ff @(posedge clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            reset_pin_out              <= 1'b0;
            reset_pin_oe               <= 1'b0;
            test_mode                  <= 1'b0;
            analog_level_output        <= 8'h00;
            address_select_test_output <= 1'b0;
            address_select_test_oe     <= 1'b0;
            irq                        <= 1'b0;
        end
        else
        begin
            reset_pin_out              <= 1'b0;
            reset_pin_oe               <= (rp_nxt == MPC_RP_PULSE);
            test_mode                  <= pins_r.test_en;
            analog_level_output        <= pins_r.test_en ? 8'h00 : dac_nxt;
            // test tree output: nand of sampled inputs
            address_select_test_output <= ~(&{pins_r.vid, pins_r.rst_in});
            address_select_test_oe     <= pins_r.test_en;
            irq                        <= |(stat_nxt & mask_nxt);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_pulse_min_len: assert property (@(posedge clk) disable iff (!srst_n)
        $rose(reset_pin_oe) |-> reset_pin_oe [*8]) else $error("reset pulse too short");
    a_pulse_starts: assert property (@(posedge clk) disable iff (!srst_n)
        (rp_r == MPC_RP_IDLE && cfg_r[CFG_RST_BIT]) |=> reset_pin_oe)
        else $error("reset pulse did not start");
    a_pulse_count: assert property (@(posedge clk) disable iff (!srst_n)
        (reset_pin_oe && cnt_r != '0) |=> reset_pin_oe)
        else $error("reset pin released before count ended");
    a_drive_low: assert property (@(posedge clk) disable iff (!srst_n)
        reset_pin_oe |-> !reset_pin_out) else $error("reset pin driven high");
    a_test_mode_follow: assert property (@(posedge clk) disable iff (!srst_n)
        test_mode == $past(pins_r.test_en)) else $error("test mode wrong");
    a_tree_oe: assert property (@(posedge clk) disable iff (!srst_n)
        address_select_test_oe == test_mode) else $error("tree output role wrong");
    a_analog_level_output_test: assert property (@(posedge clk) disable iff (!srst_n)
        test_mode |-> analog_level_output == 8'h00) else $error("analog out in test");
    a_ext_defaults: assert property (@(posedge clk) disable iff (!srst_n)
        ext_rst |=> (cfg_r == CFG_RST_VAL && mask_r == MASK_RST_VAL))
        else $error("registers not defaulted");
    a_ext_seen: assert property (@(posedge clk) disable iff (!srst_n)
        (ext_rst && !ext_prev_r) |=> stat_r[ST_EXT_RST_BIT])
        else $error("external reset not flagged");
    a_vid_irq: assert property (@(posedge clk) disable iff (!srst_n)
        (ev[0] && !ext_rst) |=> stat_r[0]) else $error("id interrupt lost");
    a_vid_read: assert property (@(posedge clk) disable iff (!srst_n)
        (rd_en && paddr == VID_LOW_OFS) |=> prdata[3:0] == $past(pins_r.vid[3:0]))
        else $error("low id read wrong");
    a_vid_top_read: assert property (@(posedge clk) disable iff (!srst_n)
        (rd_en && paddr == VID_TOP_OFS) |=> prdata[0] == $past(pins_r.vid[4]))
        else $error("top id read wrong");
endmodule : mpc_top

// ==== verif/mpc_far_model.sv ====
// far side of the pin control block: processor id outputs and the board reset network
// assumes the bench sets the id levels and asks for an external reset low
`timescale 1ns/10ps
module mpc_far_model
(
    input  wire logic       reset_pin_out,
    input  wire logic       reset_pin_oe,
    input  wire logic       ext_rst_low,
    input  wire logic [4:0] vid_drive,
    output logic            reset_pin_in,
    output logic      [4:0] voltage_id_in
);
    // ************************************************************
    // wired reset line with pull-up, id pins driven by the processor
    // ************************************************************
    // either party may pull low, otherwise the pull-up wins
    assign reset_pin_in  = ((reset_pin_oe && !reset_pin_out) || ext_rst_low) ? 1'b0 : 1'b1;
    assign voltage_id_in = vid_drive;
endmodule : mpc_far_model

// ==== verif/tb_top.sv ====
// self-checking bench for the pin control block, apb master plus far side model
// assumes a 40 MHz clock and a zero-wait apb slave as described in the hand-over
`timescale 1ns/10ps
module tb_top;
    import mpc_pkg::*;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hF2F7;
    logic        pready, pslverr, er, board_test_enable = 0, ext_low = 0;
    logic        reset_pin_in, reset_pin_out, reset_pin_oe, test_mode, irq;
    logic [4:0]  vid = 5'h1F, voltage_id_in;
    logic [7:0]  analog_level_output;
    logic        address_select_test_output, address_select_test_oe;
    int          mismatches = 0, checks_done = 0, cyc = 0;

    // ************************************************************
    // clock, instances, timeout
    // ************************************************************
    always #12.5 clk = ~clk;
    mpc_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .board_test_enable(board_test_enable), .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .voltage_id_in(voltage_id_in), .test_mode(test_mode),
        .analog_level_output(analog_level_output),
        .address_select_test_output(address_select_test_output),
        .address_select_test_oe(address_select_test_oe), .irq(irq));
    mpc_far_model far (.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .ext_rst_low(ext_low), .vid_drive(vid), .reset_pin_in(reset_pin_in),
        .voltage_id_in(voltage_id_in));
    // cut a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            results();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] exp_low(input logic [4:0] v);
        return {28'h0, v[3:0]};
    endfunction : exp_low
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wait_cyc(3);
        apb(0, CFG_OFS, 0);      chk("cfg reset", rd, 32'h0);
        apb(0, IRQ_MASK_OFS, 0); chk("mask reset", rd, 32'h0);
        // random id levels, mode off so no events
        repeat (6)
        begin
            seed = lfsr(seed);
            vid <= seed[4:0];
            wait_cyc(4);
            apb(0, VID_TOP_OFS, 0); chk("id top", rd[0], {31'h0, vid[4]});
            apb(0, VID_LOW_OFS, 0); chk("id low", rd, exp_low(vid));
        end
        // test mode and analog output sharing
        board_test_enable <= 1'b1;
        wait_cyc(4);
        chk("test mode", test_mode, 1);
        chk("tree oe", address_select_test_oe, 1);
        chk("tree out", address_select_test_output, {31'h0, ~(&vid)});
        chk("dac in test", analog_level_output, 0);
        board_test_enable <= 1'b0;
        apb(1, VID_TOP_OFS, 32'h0000A500);
        wait_cyc(4);
        chk("normal mode", test_mode, 0);
        chk("tree oe off", address_select_test_oe, 0);
        chk("dac code", analog_level_output, 8'hA5);
        // id pins as interrupts, one masked
        vid <= 5'h1F;
        apb(1, VID_MODE_OFS, 32'h1F);
        apb(1, IRQ_MASK_OFS, 32'h01);
        vid <= 5'h1C;
        wait_cyc(4);
        chk("irq up", irq, 1);
        apb(0, IRQ_STAT_OFS, 0); chk("status", rd, 32'h03);
        apb(1, IRQ_STAT_OFS, 32'h01);
        wait_cyc(3);
        chk("irq masked", irq, 0);
        apb(0, IRQ_STAT_OFS, 0); chk("status w1c", rd, 32'h02);
        // unmapped place
        apb(0, 8'h60, 0);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 32'h0);
        // external reset low on the pin
        apb(1, IRQ_MASK_OFS, 32'h7F);
        ext_low <= 1'b1;
        wait_cyc(3);
        ext_low <= 1'b0;
        wait_cyc(4);
        apb(0, IRQ_MASK_OFS, 0); chk("mask cleared", rd, 32'h0);
        apb(0, IRQ_STAT_OFS, 0); chk("ext flag", rd, 32'h20);
        apb(0, VID_MODE_OFS, 0); chk("mode cleared", rd, 32'h0);
        // outgoing reset pulse, start and early hold only
        apb(1, CFG_OFS, 32'h10);
        wait_cyc(3);
        chk("pulse oe", reset_pin_oe, 1);
        chk("pulse low", reset_pin_out, 0);
        wait_cyc(2000);
        chk("pulse held", reset_pin_oe, 1);
        chk("pin level", reset_pin_in, 0);
        apb(0, CFG_OFS, 0); chk("request self clears", rd[4], 0);
        results();
    end
endmodule : tb_top
